// ---- inc/pbil_pkg.sv ----
// Notes on behaviour
// - Button feeds one selectable input function; selection resets to code 9 (position preset).
// - Polarity bit set to 1 inverts the button sense; resets to 0.
// - Release needs a continuous hold of 1 to 50 tenths, default 10; 0 disables interlock.
// - Release window lasts 0 to 50 tenths, default 30, then interlock returns.
// - On firing, both indicators stay lit for 0 to 50 tenths, default 10.
// - Both indicators blink while the release window is open.
// - Function fires on a fresh second press inside the window, never on the hold.
// - After the monitor time only the power indicator stays lit.
// - Once the window expires, single presses are ignored until a new full hold.
package pbil_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_TIME_NS = 100_000_000;
  localparam int unsigned TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned DEB_TIME_NS = 10_000_000;
  localparam int unsigned DEB_CYCLES = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 21;
  localparam logic [7:0] OFS_FUNC = 8'h00;
  localparam logic [7:0] OFS_INVERT = 8'h04;
  localparam logic [7:0] OFS_HOLD = 8'h08;
  localparam logic [7:0] OFS_WINDOW = 8'h0c;
  localparam logic [7:0] OFS_MONITOR = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] RST_FUNC = 8'h09;
  localparam logic RST_INVERT = 1'b0;
  localparam logic [5:0] RST_HOLD = 6'h0a;
  localparam logic [5:0] RST_WINDOW = 6'h1e;
  localparam logic [5:0] RST_MONITOR = 6'h0a;
  localparam logic [5:0] TIME_MAX = 6'h32;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_LEVEL_BIT = 2;
  localparam int unsigned ST_RELSEEN_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    PBIL_IDLE = 2'b00,
    PBIL_HOLD = 2'b01,
    PBIL_WIN = 2'b11,
    PBIL_MON = 2'b10
  } pbil_state_t;
endpackage

// ---- testbench/pbil_operator.sv ----
`timescale 1ns/10ps
module pbil_operator (
  input wire logic aclk,
  output logic btn_raw
);
  initial btn_raw = 1'b0;
  // Contact bounce on every press, so the debounce is never bypassed
  task push;
    btn_raw <= 1'b1;
    @(posedge aclk);
    btn_raw <= 1'b0;
    @(posedge aclk);
    btn_raw <= 1'b1;
  endtask
  // Full release; the operator lets go before any second press
  task let_go;
    btn_raw <= 1'b0;
  endtask
endmodule

// ---- testbench/pbil_props.sv ----
`timescale 1ns/10ps
module pbil_props #(
  parameter int unsigned TICK_CYCLES = pbil_pkg::TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [7:0] func_code,
  input wire logic func_fire,
  input wire logic power_led,
  input wire logic alarm_led
);
  // Dark run length; a stuck blink shows up as an overlong run
  int unsigned dark_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || power_led) begin
      dark_q <= 0;
    end else begin
      dark_q <= dark_q + 1;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_FIRE_PULSE: assert property (func_fire |=> !func_fire)
    else $error("fire pulse longer than one cycle");
  AST_LED_PAIR: assert property (alarm_led |-> power_led)
    else $error("alarm lit while power dark");
  AST_FIRE_LIT: assert property (func_fire |-> ##[0:1] (power_led && alarm_led))
    else $error("indicators not lit on fire");
  AST_FUNC_RST: assert property ($rose(aresetn) |-> func_code == 8'h09)
    else $error("function code not 9 after reset");
  AST_LED_RST: assert property ($rose(aresetn) |=> power_led && !alarm_led)
    else $error("indicators wrong after reset");
  AST_BLINK_HALF: assert property (dark_q <= TICK_CYCLES)
    else $error("power dark longer than one tick");
  AST_WR_RESP: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_RD_RESP: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
endmodule

// ---- testbench/pbil_tb_top.sv ----
`timescale 1ns/10ps
module pbil_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic btn_raw;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata;
  logic [7:0] func_code;
  logic func_fire, func_level, power_led, alarm_led;
  int err_count = 0;
  int compares = 0;
  int fires = 0;
  int dark = 0;
  int f0, d0;
  always #50 aclk = ~aclk;
  pbil_operator op (.aclk(aclk), .btn_raw(btn_raw));
  // Short tick and debounce keep the run brief; all waits scale from 20 and 3
  pbil_top #(.TICK_CYCLES(20), .DEB_CYCLES(3)) dut (
    .aclk(aclk), .aresetn(aresetn), .panel_pushbutton_input(btn_raw),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .func_code(func_code),
    .func_fire(func_fire), .func_level(func_level), .power_led(power_led),
    .alarm_led(alarm_led)
  );
  always @(posedge aclk) begin
    if (func_fire === 1'b1) fires <= fires + 1;
    if (aresetn && power_led === 1'b0) dark <= dark + 1;
  end
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task test_done;
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string n);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(n, s_axi_rdata, exp);
    chk(n, {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(pbil_pkg::OFS_FUNC, 32'h9, pbil_pkg::RESP_OKAY, "func");
    rd(pbil_pkg::OFS_INVERT, 32'h0, pbil_pkg::RESP_OKAY, "invert");
    rd(pbil_pkg::OFS_HOLD, 32'ha, pbil_pkg::RESP_OKAY, "hold");
    rd(pbil_pkg::OFS_WINDOW, 32'h1e, pbil_pkg::RESP_OKAY, "window");
    rd(pbil_pkg::OFS_MONITOR, 32'ha, pbil_pkg::RESP_OKAY, "monitor");
    rd(8'h18, 32'h0, pbil_pkg::RESP_SLVERR, "unmapped");
    wr(pbil_pkg::OFS_STATUS, 32'h0);
    chk("status write", {30'h0, rr}, {30'h0, pbil_pkg::RESP_SLVERR});
    wr(pbil_pkg::OFS_HOLD, 32'h3f);
    rd(pbil_pkg::OFS_HOLD, 32'h32, pbil_pkg::RESP_OKAY, "clamp");
    wr(pbil_pkg::OFS_FUNC, 32'h2a);
    chk("code", {24'h0, func_code}, 32'h2a);
    // Low byte lane off: accepted but must leave the selection alone
    s_axi_wstrb <= 4'he;
    wr(pbil_pkg::OFS_FUNC, 32'h55);
    chk("strobe resp", {30'h0, rr}, {30'h0, pbil_pkg::RESP_OKAY});
    s_axi_wstrb <= 4'hf;
    rd(pbil_pkg::OFS_FUNC, 32'h2a, pbil_pkg::RESP_OKAY, "strobe");
    wr(pbil_pkg::OFS_HOLD, 32'h2);
    wr(pbil_pkg::OFS_WINDOW, 32'h5);
    wr(pbil_pkg::OFS_MONITOR, 32'h2);
    // Raw line idle low reads as pressed once inverted
    wr(pbil_pkg::OFS_INVERT, 32'h1);
    repeat (10) @(posedge aclk);
    rd(pbil_pkg::OFS_STATUS, 32'h5, pbil_pkg::RESP_OKAY, "inverted");
    wr(pbil_pkg::OFS_INVERT, 32'h0);
    repeat (10) @(posedge aclk);
    rd(pbil_pkg::OFS_STATUS, 32'h0, pbil_pkg::RESP_OKAY, "plain");
    d0 = dark;
    op.push();
    repeat (25) @(posedge aclk);
    op.let_go();
    repeat (60) @(posedge aclk);
    chk("short hold", dark - d0, 0);
    f0 = fires;
    op.push();
    repeat (40) @(posedge aclk);
    rd(pbil_pkg::OFS_STATUS, 32'h5, pbil_pkg::RESP_OKAY, "holding");
    repeat (10) @(posedge aclk);
    rd(pbil_pkg::OFS_STATUS, 32'h7, pbil_pkg::RESP_OKAY, "released");
    for (int i = 0; i < 100 && power_led !== 1'b0; i++) @(posedge aclk);
    chk("blink", {30'h0, power_led, alarm_led}, 32'h0);
    chk("fire on hold", fires - f0, 0);
    op.let_go();
    repeat (10) @(posedge aclk);
    op.push();
    repeat (15) @(posedge aclk);
    chk("fire", fires - f0, 1);
    op.let_go();
    repeat (20) @(posedge aclk);
    chk("monitor", {30'h0, power_led, alarm_led}, 32'h3);
    repeat (25) @(posedge aclk);
    chk("normal", {30'h0, power_led, alarm_led}, 32'h2);
    f0 = fires;
    op.push();
    repeat (120) @(posedge aclk);
    rd(pbil_pkg::OFS_STATUS, 32'h7, pbil_pkg::RESP_OKAY, "window open");
    repeat (40) @(posedge aclk);
    rd(pbil_pkg::OFS_STATUS, 32'h4, pbil_pkg::RESP_OKAY, "window shut");
    op.let_go();
    repeat (10) @(posedge aclk);
    op.push();
    repeat (15) @(posedge aclk);
    op.let_go();
    repeat (60) @(posedge aclk);
    chk("expired", fires - f0, 0);
    wr(pbil_pkg::OFS_HOLD, 32'h0);
    f0 = fires;
    op.push();
    repeat (12) @(posedge aclk);
    chk("direct fire", fires - f0, 1);
    chk("level on", {31'h0, func_level}, 32'h1);
    op.let_go();
    repeat (12) @(posedge aclk);
    chk("level off", {31'h0, func_level}, 32'h0);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(pbil_pkg::OFS_FUNC, 32'h9, pbil_pkg::RESP_OKAY, "func again");
    test_done();
  end
endmodule
bind pbil_top pbil_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .func_code(func_code), .func_fire(func_fire),
  .power_led(power_led), .alarm_led(alarm_led)
);

// ---- verilog/pbil_top.sv ----
`timescale 1ns/10ps
module pbil_top #(
  parameter int unsigned TICK_CYCLES = pbil_pkg::TICK_CYCLES,
  parameter int unsigned DEB_CYCLES = pbil_pkg::DEB_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic panel_pushbutton_input,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] func_code,
  output logic func_fire,
  output logic func_level,
  output logic power_led,
  output logic alarm_led
);
  logic sync1_q, sync2_q, stable_q;
  logic [pbil_pkg::CNT_W-1:0] deb_q;
  logic pressed, pressed_q, press_edge;
  logic [7:0] func_q;
  logic invert_q;
  logic [5:0] hold_q, win_q, mon_q;
  logic [5:0] time_in;
  pbil_pkg::pbil_state_t state_q, state_d;
  logic [pbil_pkg::CNT_W-1:0] presc_q;
  logic [5:0] steps_q;
  logic [6:0] steps_nxt;
  logic tick, fire_d, rel_seen_q, blink_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_have_q, w_have_q, wr_go;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic fire_q, level_q, pled_q, aled_q;

  // Two flops first, then a stable-for-DEB_CYCLES filter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= panel_pushbutton_input;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deb_q <= '0;
      stable_q <= 1'b0;
    end else if (sync2_q == stable_q) begin
      deb_q <= '0;
    end else if (deb_q >= pbil_pkg::CNT_W'(DEB_CYCLES - 1)) begin
      deb_q <= '0;
      stable_q <= sync2_q;
    end else begin
      deb_q <= deb_q + 1'b1;
    end
  end

  assign pressed = stable_q ^ invert_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pressed_q <= 1'b0;
    end else begin
      pressed_q <= pressed;
    end
  end

  assign press_edge = pressed && !pressed_q;

  // Tick restarts on every state change so each period is exact
  assign tick = (presc_q == pbil_pkg::CNT_W'(TICK_CYCLES - 1));
  assign steps_nxt = {1'b0, steps_q} + 7'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn || state_d != state_q) begin
      presc_q <= '0;
      steps_q <= '0;
    end else if (tick) begin
      presc_q <= '0;
      steps_q <= steps_nxt[5:0];
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    fire_d = 1'b0;
    unique case (state_q)
      pbil_pkg::PBIL_IDLE: begin
        if (press_edge && hold_q == 6'h00) begin
          fire_d = 1'b1;
          state_d = (mon_q == 6'h00) ? pbil_pkg::PBIL_IDLE : pbil_pkg::PBIL_MON;
        end else if (press_edge) begin
          state_d = pbil_pkg::PBIL_HOLD;
        end
      end
      pbil_pkg::PBIL_HOLD: begin
        if (!pressed) begin
          state_d = pbil_pkg::PBIL_IDLE;
        end else if (tick && steps_nxt >= {1'b0, hold_q}) begin
          state_d = pbil_pkg::PBIL_WIN;
        end
      end
      pbil_pkg::PBIL_WIN: begin
        if (rel_seen_q && press_edge) begin
          fire_d = 1'b1;
          state_d = (mon_q == 6'h00) ? pbil_pkg::PBIL_IDLE : pbil_pkg::PBIL_MON;
        end else if (win_q == 6'h00 || (tick && steps_nxt >= {1'b0, win_q})) begin
          state_d = pbil_pkg::PBIL_IDLE;
        end
      end
      pbil_pkg::PBIL_MON: begin
        if (mon_q == 6'h00 || (tick && steps_nxt >= {1'b0, mon_q})) begin
          state_d = pbil_pkg::PBIL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= pbil_pkg::PBIL_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // The hold itself never counts as the second press
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != pbil_pkg::PBIL_WIN) begin
      rel_seen_q <= 1'b0;
    end else if (!pressed) begin
      rel_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != pbil_pkg::PBIL_WIN) begin
      blink_q <= 1'b1;
    end else if (tick) begin
      blink_q <= !blink_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fire_q <= 1'b0;
      level_q <= 1'b0;
      pled_q <= 1'b0;
      aled_q <= 1'b0;
    end else begin
      fire_q <= fire_d;
      level_q <= (hold_q == 6'h00) ? pressed : fire_d;
      unique case (state_d)
        pbil_pkg::PBIL_WIN: begin
          pled_q <= (state_q == pbil_pkg::PBIL_WIN) ? blink_q : 1'b1;
          aled_q <= (state_q == pbil_pkg::PBIL_WIN) ? blink_q : 1'b1;
        end
        pbil_pkg::PBIL_MON: begin
          pled_q <= 1'b1;
          aled_q <= 1'b1;
        end
        default: begin
          pled_q <= 1'b1;
          aled_q <= 1'b0;
        end
      endcase
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b1;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && awready_q) begin
      aw_have_q <= 1'b1;
      awready_q <= 1'b0;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b1;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      w_have_q <= 1'b1;
      wready_q <= 1'b0;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= pbil_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= (aw_addr_q > pbil_pkg::OFS_MONITOR || aw_addr_q[1:0] != 2'b00) ?
                 pbil_pkg::RESP_SLVERR : pbil_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Over-range values in the low data byte clamp to the top of the legal range; bits above it are ignored
  assign time_in = (w_data_q[7:0] > {2'b00, pbil_pkg::TIME_MAX}) ?
                   pbil_pkg::TIME_MAX : w_data_q[5:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_q <= pbil_pkg::RST_FUNC;
      invert_q <= pbil_pkg::RST_INVERT;
      hold_q <= pbil_pkg::RST_HOLD;
      win_q <= pbil_pkg::RST_WINDOW;
      mon_q <= pbil_pkg::RST_MONITOR;
    end else if (wr_go && w_strb_q[0]) begin
      unique case (aw_addr_q)
        pbil_pkg::OFS_FUNC: func_q <= w_data_q[7:0];
        pbil_pkg::OFS_INVERT: invert_q <= w_data_q[0];
        pbil_pkg::OFS_HOLD: hold_q <= time_in;
        pbil_pkg::OFS_WINDOW: win_q <= time_in;
        pbil_pkg::OFS_MONITOR: mon_q <= time_in;
        default: ;
      endcase
    end
  end

  // AXI4-Lite read, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= pbil_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= pbil_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      unique case (s_axi_araddr)
        pbil_pkg::OFS_FUNC: rdata_q[7:0] <= func_q;
        pbil_pkg::OFS_INVERT: rdata_q[0] <= invert_q;
        pbil_pkg::OFS_HOLD: rdata_q[5:0] <= hold_q;
        pbil_pkg::OFS_WINDOW: rdata_q[5:0] <= win_q;
        pbil_pkg::OFS_MONITOR: rdata_q[5:0] <= mon_q;
        pbil_pkg::OFS_STATUS: begin
          rdata_q[pbil_pkg::ST_STATE_LSB +: 2] <= state_q;
          rdata_q[pbil_pkg::ST_LEVEL_BIT] <= pressed;
          rdata_q[pbil_pkg::ST_RELSEEN_BIT] <= rel_seen_q;
        end
        default: rresp_q <= pbil_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign func_code = func_q;
  assign func_fire = fire_q;
  assign func_level = level_q;
  assign power_led = pled_q;
  assign alarm_led = aled_q;
endmodule
